// file: bcsp_pkg.sv
// Shared constants of the board control and status port
package bcsp_pkg;
	// Port offsets within the eight-port block (A0-A2)
	localparam logic [2:0] OFF_PARALLEL_DATA = 3'h0;
	localparam logic [2:0] OFF_STD_SERIAL_DATA = 3'h2;
	localparam logic [2:0] OFF_STD_SERIAL_CTRL = 3'h3;
	localparam logic [2:0] OFF_SEC_SERIAL_DATA = 3'h4;
	localparam logic [2:0] OFF_SEC_SERIAL_CTRL = 3'h5;
	localparam logic [2:0] OFF_BOARD_CMD_STATUS = 3'h6;
	// Port group selects, from address bits A2-A1
	localparam int GRP_PARALLEL = 0;
	localparam int GRP_STD_SERIAL = 1;
	localparam int GRP_SEC_SERIAL = 2;
	localparam int GRP_BOARD = 3;
	localparam int GRP_W = 4;
	// Command byte codes
	localparam logic [7:0] CMD_SERIAL_RESET = 8'h00;
	localparam logic [3:0] CMD_GROUP_HI = 4'h1;
	localparam logic [7:0] CMD_PO_CLR = 8'h20;
	localparam logic [7:0] CMD_PI_CLR = 8'h30;
	localparam logic [7:0] CMD_RTC_DISARM = 8'h40;
	localparam logic [7:0] CMD_RTC_CLR = 8'h50;
	localparam logic [7:0] CMD_PO_SET = 8'h60;
	localparam logic [7:0] CMD_RTC_ARM = 8'hC0;
	// Arming bit positions, also the interrupt request positions
	localparam int ARM_PI = 0;
	localparam int ARM_PO = 1;
	localparam int ARM_STD_TXRDY = 2;
	localparam int ARM_STD_TXEMPTY = 3;
	localparam int ARM_SEC_TXRDY = 4;
	localparam int ARM_SEC_TXEMPTY = 5;
	localparam int ARM_RTC = 6;
	localparam int ARM_W = 7;
	// Carrier-detect inhibit positions
	localparam int INH_STD = 0;
	localparam int INH_SEC = 1;
	localparam int INH_W = 2;
	// Status byte bit positions
	localparam int ST_PO_FLAG = 7;
	localparam int ST_PI_FLAG = 6;
	localparam int ST_RTC_FLAG = 5;
	localparam int ST_PO_ACK = 4;
	localparam int ST_SEC_CARRIER = 3;
	localparam int ST_STD_CARRIER = 2;
	localparam int ST_SPARE_HIGH = 1;
	localparam int ST_SPARE_LOW = 0;
	// Reset values
	localparam logic [ARM_W-1:0] ARM_RESET = 7'h00;
	localparam logic [INH_W-1:0] INH_RESET = 2'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [ARM_W-1:0] IRQ_N_RESET = 7'h7F;
	// Real-time clock divider
	localparam int RTC_DIV_W = 14;
	localparam int RTC_RATES = 12;
	localparam int RTC_SEL_W = 4;
	localparam int RTC_MIN_INTERVAL_US = 3328;
	localparam int RTC_MAX_INTERVAL_MS = 27263;
	localparam logic [RTC_DIV_W-1:0] RTC_DIV_RESET = 14'h0000;
endpackage : bcsp_pkg

// file: bcsp_ctl_if.sv
// Internal carrier between the board port top, its decoder and its clock
`timescale 1ns/10ps
`default_nettype none
interface bcsp_ctl_if;
	logic cmd_stb;
	logic [7:0] cmd_code;
	logic [bcsp_pkg::ARM_W-1:0] arm;
	logic [bcsp_pkg::INH_W-1:0] inhibit;
	logic po_set;
	logic po_clr;
	logic pi_clr;
	logic rtc_clr;
	logic tap_rise;
	logic [bcsp_pkg::RTC_SEL_W-1:0] rtc_sel;
	logic rtc_tick;
	modport top (
		output cmd_stb, cmd_code, tap_rise, rtc_sel,
		input arm, inhibit, po_set, po_clr, pi_clr, rtc_clr, rtc_tick
	);
	modport dec (
		input cmd_stb, cmd_code,
		output arm, inhibit, po_set, po_clr, pi_clr, rtc_clr
	);
	modport rtc (
		input tap_rise, rtc_sel,
		output rtc_tick
	);
endinterface : bcsp_ctl_if
`default_nettype wire

// file: bcsp_rtc_div.sv
// Real-time clock divider and interval select
`timescale 1ns/10ps
`default_nettype none
module bcsp_rtc_div (
	input wire logic mclk_i,
	input wire logic rst_i,
	bcsp_ctl_if.rtc ctl
);
	logic [bcsp_pkg::RTC_DIV_W-1:0] div;
	logic [bcsp_pkg::RTC_DIV_W-1:0] next_div;
	logic tap_bit;
	logic tap_prev;
	logic next_tap_prev;
	logic sel_ok;
	logic [bcsp_pkg::RTC_SEL_W-1:0] bit_idx;

	// Rate 0 uses the first stage, the rest skip two stages
	always_comb
	begin
		sel_ok = (ctl.rtc_sel < 4'(bcsp_pkg::RTC_RATES));
		bit_idx = (ctl.rtc_sel == 4'h0) ? 4'h0 : ctl.rtc_sel + 4'h2;
		next_div = ctl.tap_rise ? div + 14'h0001 : div;
		tap_bit = sel_ok ? div[bit_idx] : 1'b0;
		next_tap_prev = tap_bit;
		ctl.rtc_tick = tap_bit & ~tap_prev;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div <= bcsp_pkg::RTC_DIV_RESET;
			tap_prev <= 1'b0;
		end
		else
		begin
			div <= next_div;
			tap_prev <= next_tap_prev;
		end
	end
endmodule : bcsp_rtc_div
`default_nettype wire

// file: bcsp_cmd_dec.sv
// Board command byte decoder with arming and inhibit bits
`timescale 1ns/10ps
`default_nettype none
module bcsp_cmd_dec (
	input wire logic mclk_i,
	input wire logic rst_i,
	bcsp_ctl_if.dec ctl
);
	logic [bcsp_pkg::ARM_W-1:0] arm;
	logic [bcsp_pkg::ARM_W-1:0] next_arm;
	logic [bcsp_pkg::INH_W-1:0] inhibit;
	logic [bcsp_pkg::INH_W-1:0] next_inhibit;
	logic [7:0] c;
	logic grp;

	always_comb
	begin
		c = ctl.cmd_code;
		grp = ctl.cmd_stb && (c[7:4] == bcsp_pkg::CMD_GROUP_HI);
		next_arm = arm;
		next_inhibit = inhibit;
		if (ctl.cmd_stb && c == bcsp_pkg::CMD_SERIAL_RESET)
		begin
			next_arm[bcsp_pkg::ARM_SEC_TXEMPTY:bcsp_pkg::ARM_STD_TXRDY] = 4'h0;
			next_inhibit = bcsp_pkg::INH_RESET;
		end
		// Low bit of a group code is arm or inhibit, upper bits pick the target
		if (grp && c[3] == 1'b0)
			next_arm[c[2:1]] = c[0];
		if (grp && c[3:2] == 2'h2)
			next_inhibit[c[1]] = c[0];
		if (grp && c[3:2] == 2'h3)
			next_arm[bcsp_pkg::ARM_SEC_TXRDY + int'(c[1])] = c[0];
		if (ctl.cmd_stb && c == bcsp_pkg::CMD_RTC_ARM)
			next_arm[bcsp_pkg::ARM_RTC] = 1'b1;
		if (ctl.cmd_stb && c == bcsp_pkg::CMD_RTC_DISARM)
			next_arm[bcsp_pkg::ARM_RTC] = 1'b0;
		ctl.po_set = ctl.cmd_stb && c == bcsp_pkg::CMD_PO_SET;
		ctl.po_clr = ctl.cmd_stb && c == bcsp_pkg::CMD_PO_CLR;
		ctl.pi_clr = ctl.cmd_stb && c == bcsp_pkg::CMD_PI_CLR;
		ctl.rtc_clr = ctl.cmd_stb && c == bcsp_pkg::CMD_RTC_CLR;
		ctl.arm = arm;
		ctl.inhibit = inhibit;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			arm <= bcsp_pkg::ARM_RESET;
			inhibit <= bcsp_pkg::INH_RESET;
		end
		else
		begin
			arm <= next_arm;
			inhibit <= next_inhibit;
		end
	end
endmodule : bcsp_cmd_dec
`default_nettype wire

// file: bcsp_top.sv
// Board control and status port: decode, flags, status byte and interrupts
//
// Function
// - Baud tap divided by a 14-bit counter, 12 intervals, 3.328 ms to 27.263 s.
// - Each selected tick sets the clock flag; it holds until software clears it.
// - The clock flag reads as status bit 5.
// - Code C0 arms clock interrupt, 40 disarms it, 50 clears clock flag.
// - Code 20 clears, 60 sets output flag; 30 clears input flag.
// - Code 00 clears all serial arming bits and carrier inhibits.
// - Code 11 arms parallel input, 12 disarms parallel output interrupt.
// - Code 17 arms standard transmitter-empty interrupt.
// - Codes 18/19 allow/inhibit standard carrier, 1A/1B the second.
// - Codes 1C/1D and 1E/1F disarm/arm second ready and empty interrupts.
// - Reads of offset 6 return the status byte.
// - Bits 7,6,4: output flag, input flag, ack; bits 3,2 carriers active low.
// - Bits 1 and 0 show the two user spare inputs.
// - Respond only when A3-A7 match the configured block value.
// - A1-A2 pick parallel, standard serial, second serial or board ports.
// - Power-on clear drives every flag, arm and inhibit bit inactive.
`timescale 1ns/10ps
`default_nettype none
module bcsp_top (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] io_addr_i,
	input wire logic [7:0] io_data_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	output logic [7:0] io_data_o,
	output logic io_data_oe_n_o,
	output logic [bcsp_pkg::GRP_W-1:0] port_sel_o,
	input wire logic [4:0] port_block_i,
	input wire logic [bcsp_pkg::RTC_SEL_W-1:0] rtc_rate_sel_i,
	input wire logic baud_tap_i,
	input wire logic par_in_strobe_i,
	input wire logic par_out_ack_i,
	input wire logic std_carrier_n_i,
	input wire logic sec_carrier_n_i,
	input wire logic std_tx_ready_i,
	input wire logic std_tx_empty_i,
	input wire logic sec_tx_ready_i,
	input wire logic sec_tx_empty_i,
	input wire logic spare_status_jumper_low_i,
	input wire logic spare_status_jumper_high_i,
	output logic [bcsp_pkg::ARM_W-1:0] irq_n_o,
	output logic po_flag_o,
	output logic pi_flag_o
);
	localparam int SYNC_W = 20;

	bcsp_ctl_if ctl ();

	// Pins and straps are asynchronous to mclk_i
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_q;
	logic [4:0] blk_s;
	logic [bcsp_pkg::RTC_SEL_W-1:0] rate_s;
	logic tap_s;
	logic pis_s;
	logic ack_s;
	logic std_cd_s;
	logic sec_cd_s;
	logic [3:0] tx_s;
	logic spare_lo_s;
	logic spare_hi_s;

	// Edge history of the synchronised strobes and the write strobe
	logic tap_prev;
	logic next_tap_prev;
	logic pis_prev;
	logic next_pis_prev;
	logic ack_prev;
	logic next_ack_prev;
	logic wr_prev;
	logic next_wr_prev;

	logic po_flag;
	logic next_po_flag;
	logic pi_flag;
	logic next_pi_flag;
	logic rtc_tick_flag;
	logic next_rtc_tick_flag;

	logic [7:0] rd_data;
	logic [7:0] next_rd_data;
	logic [bcsp_pkg::ARM_W-1:0] irq_n;
	logic [bcsp_pkg::ARM_W-1:0] next_irq_n;

	logic blk_hit;
	logic board_hit;
	logic cmd_stb;
	logic [7:0] status;
	logic [bcsp_pkg::ARM_W-1:0] irq_src;
	logic [bcsp_pkg::GRP_W-1:0] grp_onehot;

	assign sync_in = {
		port_block_i,
		rtc_rate_sel_i,
		baud_tap_i,
		par_in_strobe_i,
		par_out_ack_i,
		std_carrier_n_i,
		sec_carrier_n_i,
		std_tx_ready_i,
		std_tx_empty_i,
		sec_tx_ready_i,
		sec_tx_empty_i,
		spare_status_jumper_low_i,
		spare_status_jumper_high_i
	};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge mclk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					sync_meta[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else
				begin
					sync_meta[gi] <= sync_in[gi];
					sync_q[gi] <= sync_meta[gi];
				end
			end
		end
	endgenerate

	assign blk_s = sync_q[19:15];
	assign rate_s = sync_q[14:11];
	assign tap_s = sync_q[10];
	assign pis_s = sync_q[9];
	assign ack_s = sync_q[8];
	assign std_cd_s = sync_q[7];
	assign sec_cd_s = sync_q[6];
	assign tx_s = sync_q[5:2];
	assign spare_lo_s = sync_q[1];
	assign spare_hi_s = sync_q[0];

	// Bus decode is combinational so the group select follows the strobe
	always_comb
	begin
		blk_hit = (io_addr_i[7:3] == blk_s);
		board_hit = blk_hit &&
			(io_addr_i[2:1] == bcsp_pkg::OFF_BOARD_CMD_STATUS[2:1]);
		grp_onehot = '0;
		grp_onehot[io_addr_i[2:1]] = blk_hit && (io_rd_i || io_wr_i);
		// One command per write, however long the strobe is held
		cmd_stb = board_hit && io_wr_i && !wr_prev;
	end

	assign port_sel_o = grp_onehot;
	assign io_data_oe_n_o = !(board_hit && io_rd_i);
	assign io_data_o = rd_data;

	assign ctl.cmd_stb = cmd_stb;
	assign ctl.cmd_code = io_data_i;
	assign ctl.tap_rise = tap_s && !tap_prev;
	assign ctl.rtc_sel = rate_s;

	bcsp_cmd_dec u_dec (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ctl(ctl.dec)
	);

	bcsp_rtc_div u_rtc (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ctl(ctl.rtc)
	);

	// Edge history, kept apart from the flags it qualifies
	always_comb
	begin
		next_tap_prev = tap_s;
		next_pis_prev = pis_s;
		next_ack_prev = ack_s;
		next_wr_prev = io_wr_i;
	end

	// Flags: a hardware set in the same cycle as a clear command wins
	always_comb
	begin
		next_po_flag = po_flag;
		if (ctl.po_clr)
			next_po_flag = 1'b0;
		if (ctl.po_set || (ack_s && !ack_prev))
			next_po_flag = 1'b1;
		next_pi_flag = pi_flag;
		if (ctl.pi_clr)
			next_pi_flag = 1'b0;
		if (pis_s && !pis_prev)
			next_pi_flag = 1'b1;
		next_rtc_tick_flag = rtc_tick_flag;
		if (ctl.rtc_clr)
			next_rtc_tick_flag = 1'b0;
		if (ctl.rtc_tick)
			next_rtc_tick_flag = 1'b1;
	end

	// Status byte, captured every cycle so the bus sees a flop output
	always_comb
	begin
		status = bcsp_pkg::STATUS_RESET;
		status[bcsp_pkg::ST_PO_FLAG] = po_flag;
		status[bcsp_pkg::ST_PI_FLAG] = pi_flag;
		status[bcsp_pkg::ST_RTC_FLAG] = rtc_tick_flag;
		status[bcsp_pkg::ST_PO_ACK] = ack_s;
		status[bcsp_pkg::ST_SEC_CARRIER] =
			ctl.inhibit[bcsp_pkg::INH_SEC] | sec_cd_s;
		status[bcsp_pkg::ST_STD_CARRIER] =
			ctl.inhibit[bcsp_pkg::INH_STD] | std_cd_s;
		status[bcsp_pkg::ST_SPARE_HIGH] = spare_hi_s;
		status[bcsp_pkg::ST_SPARE_LOW] = spare_lo_s;
		next_rd_data = status;
	end

	// Interrupt requests, registered to keep the backplane lines glitch free
	always_comb
	begin
		irq_src[bcsp_pkg::ARM_PI] = pi_flag;
		irq_src[bcsp_pkg::ARM_PO] = po_flag;
		irq_src[bcsp_pkg::ARM_STD_TXRDY] = tx_s[3];
		irq_src[bcsp_pkg::ARM_STD_TXEMPTY] = tx_s[2];
		irq_src[bcsp_pkg::ARM_SEC_TXRDY] = tx_s[1];
		irq_src[bcsp_pkg::ARM_SEC_TXEMPTY] = tx_s[0];
		irq_src[bcsp_pkg::ARM_RTC] = rtc_tick_flag;
		next_irq_n = ~(irq_src & ctl.arm);
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tap_prev <= 1'b0;
			pis_prev <= 1'b0;
			ack_prev <= 1'b0;
			wr_prev <= 1'b0;
		end
		else
		begin
			tap_prev <= next_tap_prev;
			pis_prev <= next_pis_prev;
			ack_prev <= next_ack_prev;
			wr_prev <= next_wr_prev;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			po_flag <= 1'b0;
			pi_flag <= 1'b0;
			rtc_tick_flag <= 1'b0;
		end
		else
		begin
			po_flag <= next_po_flag;
			pi_flag <= next_pi_flag;
			rtc_tick_flag <= next_rtc_tick_flag;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_data <= bcsp_pkg::STATUS_RESET;
		end
		else
		begin
			rd_data <= next_rd_data;
		end
	end

	// Requests rest released so no line is pulled while reset lasts
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			irq_n <= bcsp_pkg::IRQ_N_RESET;
		end
		else
		begin
			irq_n <= next_irq_n;
		end
	end

	assign irq_n_o = irq_n;
	assign po_flag_o = po_flag;
	assign pi_flag_o = pi_flag;
endmodule : bcsp_top
`default_nettype wire

// file: bcsp_top_chk.sv
// Assertion checker of the board control and status port
`timescale 1ns/10ps
`default_nettype none
module bcsp_top_chk (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] io_addr_i,
	input wire logic [7:0] io_data_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_data_o,
	input wire logic io_data_oe_n_o,
	input wire logic [bcsp_pkg::GRP_W-1:0] port_sel_o,
	input wire logic [bcsp_pkg::ARM_W-1:0] irq_n_o,
	input wire logic po_flag_o,
	input wire logic pi_flag_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic cmd;
	// Strobe level only; the edge test is in each assert that uses it, not in the c_rtc_arm cover
	assign cmd = io_wr_i && port_sel_o[3];
	a_sel_one_hot: assert property ($onehot0(port_sel_o))
		else $error("more than one port group selected");
	a_sel_board_addr: assert property (port_sel_o[3] |->
		(io_rd_i || io_wr_i) && io_addr_i[2:1] == 2'h3)
		else $error("board group selected off offsets 6 and 7");
	a_oe_status_read: assert property (!io_data_oe_n_o ==
		(io_rd_i && port_sel_o[3]))
		else $error("status drive enable wrong");
	a_po_status_bit: assert property (
		io_data_o[7] == $past(po_flag_o))
		else $error("status bit 7 not the output flag");
	a_pi_status_bit: assert property (
		io_data_o[6] == $past(pi_flag_o))
		else $error("status bit 6 not the input flag");
	a_po_set_cmd: assert property (cmd && !$past(io_wr_i) &&
		io_data_i == 8'h60 |=> po_flag_o)
		else $error("output flag not set by command");
	a_po_clr_cmd: assert property (cmd && !$past(io_wr_i) &&
		io_data_i == 8'h20 |=> !po_flag_o)
		else $error("output flag not cleared by command");
	a_pi_clr_cmd: assert property (cmd && !$past(io_wr_i) &&
		io_data_i == 8'h30 |=> !pi_flag_o)
		else $error("input flag not cleared by command");
	a_rtc_disarm_irq: assert property (cmd && !$past(io_wr_i) &&
		io_data_i == 8'h40 |-> ##2 irq_n_o[6])
		else $error("clock request left on after disarm");
	a_rtc_irq_flag: assert property (
		!irq_n_o[6] |-> io_data_o[5])
		else $error("clock request without clock flag");
	a_reset_idle: assert property ($fell(rst_i) |->
		irq_n_o == 7'h7F && !po_flag_o && !pi_flag_o && io_data_o == 8'h00)
		else $error("state not cleared by reset");
	c_rtc_arm: cover property (cmd && io_data_i == 8'hC0);
	c_rtc_irq: cover property (!irq_n_o[6]);
	c_status_read: cover property (!io_data_oe_n_o);
endmodule : bcsp_top_chk
bind bcsp_top bcsp_top_chk u_chk (.*);
`default_nettype wire

// file: bcsp_cpu_model.sv
// Processor model issuing backplane I/O reads and writes
`timescale 1ns/10ps
`default_nettype none
module bcsp_cpu_model (
	input wire logic mclk_i,
	input wire logic [7:0] io_data_o,
	input wire logic io_data_oe_n_o,
	output logic [7:0] addr_o,
	output logic [7:0] data_o,
	output logic rd_o,
	output logic wr_o
);
	initial
	begin
		addr_o = 8'h00;
		data_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
	end
	// Strobe drops at the taken edge, so calls back to back still
	// leave one low cycle between writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		data_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		data_o <= ~d;
	endtask : wr
	// Status is one cycle old, so the read is held for three edges
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic oe_n);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		repeat (3) @(posedge mclk_i);
		d = io_data_o;
		oe_n = io_data_oe_n_o;
		rd_o <= 1'b0;
		addr_o <= ~a;
	endtask : rd
endmodule : bcsp_cpu_model
`default_nettype wire

// file: tb_board_control_status_port.sv
// Testbench of the board control and status port
`timescale 1ns/10ps
`default_nettype none
module tb_board_control_status_port;
	localparam logic [7:0] ST = 8'hAE;
	logic mclk_i, rst_i, rd, wr, tap, pis, scn, ccn, sr, se, cr, ce, jl;
	logic ack, jh, pof, pif;
	logic [7:0] addr, wd, dout;
	logic [3:0] rate;
	logic oen;
	logic [6:0] irq;
	int fail_count, cmp_count;
	bcsp_top uut (
		.mclk_i(mclk_i), .rst_i(rst_i),
		.io_addr_i(addr), .io_data_i(wd),
		.io_rd_i(rd), .io_wr_i(wr),
		.io_data_o(dout), .io_data_oe_n_o(oen),
		.port_sel_o(), .port_block_i(5'h15),
		.rtc_rate_sel_i(rate), .baud_tap_i(tap),
		.par_in_strobe_i(pis), .par_out_ack_i(ack),
		.std_carrier_n_i(scn), .sec_carrier_n_i(ccn),
		.std_tx_ready_i(sr), .std_tx_empty_i(se),
		.sec_tx_ready_i(cr), .sec_tx_empty_i(ce),
		.spare_status_jumper_low_i(jl), .spare_status_jumper_high_i(jh),
		.irq_n_o(irq), .po_flag_o(pof), .pi_flag_o(pif)
	);
	bcsp_cpu_model cpu (.mclk_i(mclk_i), .io_data_o(dout),
		.io_data_oe_n_o(oen), .addr_o(addr), .data_o(wd), .rd_o(rd),
		.wr_o(wr));
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic st(input logic [7:0] exp);
		logic [7:0] d;
		logic oe;
		cpu.rd(ST, d, oe);
		chk("status drive", 8'h00, {7'h00, oe});
		chk("status", exp, d);
	endtask : st
	// Pulses the baud tap when w is set, the input strobe otherwise
	task automatic pulse(input logic w, input int n);
		repeat (n)
		begin
			@(posedge mclk_i);
			tap <= w;
			pis <= !w;
			repeat (2) @(posedge mclk_i);
			tap <= 1'b0;
			pis <= 1'b0;
			repeat (2) @(posedge mclk_i);
		end
		repeat (3) @(posedge mclk_i);
	endtask : pulse
	task automatic t_reset();
		st(8'h09);
		chk("irq_n", 8'h7F, {1'b0, irq});
		$display("reset test done");
	endtask : t_reset
	task automatic t_flags();
		cpu.wr(ST, 8'h60);
		st(8'h89);
		chk("po flag", 8'h01, {7'h00, pof});
		cpu.wr(ST, 8'h20);
		st(8'h09);
		pulse(1'b0, 1);
		st(8'h49);
		chk("pi flag", 8'h01, {7'h00, pif});
		cpu.wr(ST, 8'h30);
		st(8'h09);
		chk("pi flag", 8'h00, {7'h00, pif});
		$display("flag test done");
	endtask : t_flags
	task automatic t_carrier();
		@(posedge mclk_i);
		ccn <= 1'b0;
		cpu.wr(ST, 8'h19);
		st(8'h05);
		cpu.wr(ST, 8'h1B);
		st(8'h0D);
		cpu.wr(ST, 8'h18);
		st(8'h09);
		cpu.wr(ST, 8'h1A);
		st(8'h01);
		cpu.wr(ST, 8'h19);
		cpu.wr(ST, 8'h1B);
		cpu.wr(ST, 8'h00);
		st(8'h01);
		$display("carrier test done");
	endtask : t_carrier
	task automatic t_arms();
		logic [7:0] c;
		logic [6:0] e;
		e = 7'h00;
		{sr, se, cr, ce} <= 4'hF;
		cpu.wr(ST, 8'h60);
		pulse(1'b0, 1);
		// Arm codes 11,13,15,17,1D,1F; each disarm code is one below
		for (int i = 0; i < 18; i++)
		begin
			c = (i % 6 < 4) ? 8'h11 : 8'h15;
			c = c + 8'(2 * (i % 6)) - 8'(i / 6 == 1);
			e[i % 6] = (i / 6 != 1);
			cpu.wr(ST, c);
			repeat (3) @(posedge mclk_i);
			chk("irq", {1'b0, ~e}, {1'b0, irq});
		end
		cpu.wr(ST, 8'h00);
		repeat (3) @(posedge mclk_i);
		chk("irq_n", 8'h7C, {1'b0, irq});
		$display("arming test done");
	endtask : t_arms
	task automatic t_rtc();
		@(posedge mclk_i);
		rate <= 4'h1;
		pulse(1'b1, 7);
		st(8'hC1);
		pulse(1'b1, 1);
		st(8'hE1);
		cpu.wr(ST, 8'hC0);
		repeat (3) @(posedge mclk_i);
		chk("clock irq_n", 8'h00, {7'h00, irq[6]});
		cpu.wr(ST, 8'h40);
		repeat (3) @(posedge mclk_i);
		chk("clock irq_n", 8'h01, {7'h00, irq[6]});
		st(8'hE1);
		cpu.wr(ST, 8'h50);
		st(8'hC1);
		@(posedge mclk_i);
		rate <= 4'h0;
		pulse(1'b1, 1);
		st(8'hE1);
		cpu.wr(ST, 8'h50);
		@(posedge mclk_i);
		rate <= 4'hC;
		pulse(1'b1, 2);
		st(8'hC1);
		$display("clock test done");
	endtask : t_rtc
	task automatic t_block();
		logic [7:0] d;
		logic oe;
		cpu.wr(8'hB6, 8'h20);
		cpu.wr(8'hAA, 8'h20);
		st(8'hC1);
		cpu.rd(8'hB6, d, oe);
		chk("foreign drive", 8'h01, {7'h00, oe});
		cpu.wr(8'hAF, 8'h20);
		st(8'h41);
		$display("block test done");
	endtask : t_block
	task automatic t_pins();
		@(posedge mclk_i);
		ack <= 1'b1;
		jh <= 1'b1;
		repeat (2) @(posedge mclk_i);
		st(8'hD3);
		chk("po flag", 8'h01, {7'h00, pof});
		cpu.wr(ST, 8'h20);
		st(8'h53);
		$display("pin test done");
	endtask : t_pins
	initial
	begin
		rst_i = 1'b1;
		{rate, tap, pis, scn, ccn, sr, se, cr, ce, jl} = 13'h0021;
		{ack, jh} = 2'h0;
		fail_count = 0;
		cmp_count = 0;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		t_reset();
		t_flags();
		t_carrier();
		t_arms();
		t_rtc();
		t_block();
		t_pins();
		results();
	end
	initial
	begin
		repeat (50000) @(posedge mclk_i);
		fail_count++;
		results();
	end
endmodule : tb_board_control_status_port
`default_nettype wire
